// *** hw/mcs_sequencer.sv ***
// conversion sequencer: register file, averaging, limit compare and mode control
`timescale 1ns/10ps
module mcs_sequencer #(
    parameter int CONV_DIV_P   = mcs_pkg::CONV_DIV,
    parameter int IDLE_TICKS_P = mcs_pkg::IDLE_TICKS
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_n_in,
    input  wire mcs_pkg::mcs_reg_req_s reg_req_in,
    output logic                [7:0] reg_rdata_out,
    input  wire logic           [7:0] adc_sample_in,
    output logic                      adc_clk_out,
    output logic                      adc_convert_out,
    output logic                [2:0] adc_channel_out,
    output logic                      monitoring_out
);
    import mcs_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_STORE,
        ST_WAIT
    } mcs_state_e;

    mcs_state_e state;
    mcs_state_e next_state;

    logic       [7:0] start_reg;
    logic       [7:0] monitor_function_register;
    logic       [7:0] configuration_register;
    logic             soft_rst;
    logic             sw_rst;
    logic       [7:0] low_limit  [NUM_INPUTS];
    logic       [7:0] high_limit [NUM_INPUTS];
    logic       [7:0] reading    [NUM_INPUTS];
    logic       [7:0] status;
    logic       [7:0] viol_active;
    logic       [7:0] sample_meta;
    logic       [7:0] sample_sync;
    logic       [2:0] index;
    logic       [6:0] conv_cnt;
    logic       [6:0] samp_cnt;
    logic      [14:0] acc;
    logic      [15:0] wait_cnt;
    logic       [2:0] avg_latched;
    logic             cycle_mode;
    logic       [2:0] log2_samples;
    logic             conv_tick;
    logic             conv_level;
    logic             conv_last;
    logic             samp_last;
    logic       [7:0] average;
    logic             violation;
    logic             start_bit;
    logic             status_rd;

    assign sw_rst    = !rst_n_in || soft_rst;
    assign start_bit = start_reg[START_BIT];
    assign status_rd = reg_req_in.rd && (reg_req_in.addr == ADDR_STATUS);

    // soft reset pulse, self-clearing
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= reg_req_in.wr && (reg_req_in.addr == ADDR_CONFIGURATION_REGISTER)
                        && reg_req_in.wdata[SOFT_RST_BIT] && !soft_rst;
        end
    end

    // control registers
    always_ff @(posedge core_clk_in) begin
        if (sw_rst) begin
            start_reg                 <= START_RESET;
            monitor_function_register <= FUNC_RESET;
            configuration_register    <= CONFIGURATION_REGISTER_RESET;
        end else if (reg_req_in.wr) begin
            if (reg_req_in.addr == ADDR_START) begin
                start_reg <= reg_req_in.wdata;
            end
            if (reg_req_in.addr == ADDR_FUNC) begin
                monitor_function_register <= reg_req_in.wdata;
            end
            if (reg_req_in.addr == ADDR_CONFIGURATION_REGISTER) begin
                configuration_register <= {1'b0, reg_req_in.wdata[6:0]};
            end
        end
    end

    // per-input limits, readings and status
    generate
        for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_input
            localparam logic [7:0] LOW_ADDR  = 8'(ADDR_LIMIT_BASE + 8'(2 * i));
            localparam logic [7:0] HIGH_ADDR = 8'(ADDR_LIMIT_BASE + 8'(2 * i + 1));
            logic hit;
            assign hit = (state == ST_STORE) && (index == 3'(i));

            always_ff @(posedge core_clk_in) begin
                if (sw_rst) begin
                    low_limit[i]  <= LOW_LIMIT_RESET;
                    high_limit[i] <= HIGH_LIMIT_RESET;
                end else if (reg_req_in.wr && reg_req_in.addr == LOW_ADDR) begin
                    low_limit[i] <= reg_req_in.wdata;
                end else if (reg_req_in.wr && reg_req_in.addr == HIGH_ADDR) begin
                    high_limit[i] <= reg_req_in.wdata;
                end
            end

            // readings survive every reset
            always_ff @(posedge core_clk_in) begin
                if (hit) begin
                    reading[i] <= average;
                end
            end

            always_ff @(posedge core_clk_in) begin
                if (sw_rst) begin
                    viol_active[i] <= 1'b0;
                end else if (hit) begin
                    viol_active[i] <= violation;
                end
            end

            always_ff @(posedge core_clk_in) begin
                if (sw_rst) begin
                    status[i] <= 1'b0;
                end else if (hit && violation) begin
                    status[i] <= 1'b1;
                end else if (status_rd && !viol_active[i]) begin
                    status[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // read data, registered
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_req_in.rd) begin
            reg_rdata_out <= 8'h00;
            case (reg_req_in.addr)
                ADDR_START:  reg_rdata_out <= start_reg;
                ADDR_STATUS: reg_rdata_out <= status;
                ADDR_FUNC:   reg_rdata_out <= monitor_function_register;
                ADDR_CONFIGURATION_REGISTER:   reg_rdata_out <= {soft_rst, configuration_register[6:0]};
                default: begin
                    for (int k = 0; k < NUM_INPUTS; k++) begin
                        if (reg_req_in.addr == 8'(ADDR_READING_BASE + 8'(k))) begin
                            reg_rdata_out <= reading[k];
                        end
                        if (reg_req_in.addr == 8'(ADDR_LIMIT_BASE + 8'(2 * k))) begin
                            reg_rdata_out <= low_limit[k];
                        end
                        if (reg_req_in.addr == 8'(ADDR_LIMIT_BASE + 8'(2 * k + 1))) begin
                            reg_rdata_out <= high_limit[k];
                        end
                    end
                end
            endcase
        end
    end

    // converter sample from the analog side
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sample_meta <= 8'h00;
            sample_sync <= 8'h00;
        end else begin
            sample_meta <= adc_sample_in;
            sample_sync <= sample_meta;
        end
    end

    mcs_tick_gen #(
        .DIV (CONV_DIV_P)
    ) u_tick (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .clear_in    (state == ST_IDLE),
        .tick_out    (conv_tick),
        .level_out   (conv_level)
    );

    mcs_avg_decode u_avg (
        .average_count_select_in (avg_latched),
        .is_remote_in            (REMOTE_MASK[index]),
        .log2_samples_out        (log2_samples)
    );

    // conversion length by input kind
    assign conv_last = TEMP_MASK[index] ?
                       (conv_cnt == 7'(TEMPERATURE_CONVERSION_COUNT_CLKS - 1)) :
                       (conv_cnt == 7'(VOLTAGE_CONVERSION_COUNT_CLKS - 1));
    assign samp_last = ({1'b0, samp_cnt} == 8'((8'h01 << log2_samples) - 8'h01));
    assign average   = 8'(acc >> log2_samples);
    assign violation = (average < low_limit[index]) || (average > high_limit[index])
                       || (cycle_mode && ((average == low_limit[index])
                       || (average == high_limit[index])));

    // next state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_bit) begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (conv_tick && conv_last && samp_last) begin
                    next_state = ST_STORE;
                end
            end
            ST_STORE: begin
                if (index != 3'(NUM_INPUTS - 1)) begin
                    next_state = ST_CONVERT;
                end else if (cycle_mode) begin
                    next_state = ST_WAIT;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (conv_tick && wait_cnt == 16'(IDLE_TICKS_P - 1)) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (!start_bit) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sw_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // pass settings, latched at the start of each pass
    always_ff @(posedge core_clk_in) begin
        if (sw_rst) begin
            avg_latched <= FUNC_RESET[AVG_MSB:AVG_LSB];
            cycle_mode  <= 1'b0;
        end else if (state == ST_IDLE) begin
            avg_latched <= monitor_function_register[AVG_MSB:AVG_LSB];
            cycle_mode  <= monitor_function_register[MODE_BIT];
        end
    end

    // input index
    always_ff @(posedge core_clk_in) begin
        if (sw_rst || state == ST_IDLE) begin
            index <= 3'h0;
        end else if (state == ST_STORE) begin
            index <= index + 3'h1;
        end
    end

    // conversion clock count and sample count
    always_ff @(posedge core_clk_in) begin
        if (sw_rst || state != ST_CONVERT) begin
            conv_cnt <= 7'h00;
            samp_cnt <= 7'h00;
        end else if (conv_tick) begin
            if (conv_last) begin
                conv_cnt <= 7'h00;
                samp_cnt <= samp_cnt + 7'h01;
            end else begin
                conv_cnt <= conv_cnt + 7'h01;
            end
        end
    end

    // sample accumulator
    always_ff @(posedge core_clk_in) begin
        if (sw_rst || state == ST_IDLE || state == ST_STORE) begin
            acc <= 15'h0000;
        end else if (state == ST_CONVERT && conv_tick && conv_last) begin
            acc <= acc + {7'h00, sample_sync};
        end
    end

    // idle wait between passes in cycle mode
    always_ff @(posedge core_clk_in) begin
        if (sw_rst || state != ST_WAIT) begin
            wait_cnt <= 16'h0000;
        end else if (conv_tick) begin
            wait_cnt <= wait_cnt + 16'h0001;
        end
    end

    // converter control outputs
    always_ff @(posedge core_clk_in) begin
        if (sw_rst) begin
            adc_clk_out     <= 1'b0;
            adc_convert_out <= 1'b0;
            adc_channel_out <= 3'h0;
            monitoring_out  <= 1'b0;
        end else begin
            adc_clk_out     <= conv_level && (state == ST_CONVERT);
            adc_convert_out <= (state == ST_CONVERT);
            adc_channel_out <= index;
            monitoring_out  <= (state != ST_IDLE);
        end
    end

endmodule

// *** hw/mcs_pkg.sv ***
// constants, register map and carrier types for the monitor conversion sequencer
package mcs_pkg;

    // clock and conversion timing
    localparam int CLK_HZ         = 100_000_000;
    localparam int CONV_CLK_HZ    = 45_000;
    localparam int CONV_DIV       = CLK_HZ / CONV_CLK_HZ;
    localparam int TEMPERATURE_CONVERSION_COUNT_CLKS = 96;
    localparam int VOLTAGE_CONVERSION_COUNT_CLKS = 68;
    localparam int IDLE_MS        = 1000;
    localparam int IDLE_TICKS     = IDLE_MS * CONV_CLK_HZ / 1000;

    // inputs and their kinds, one bit per sequence slot
    localparam int       NUM_INPUTS  = 8;
    localparam logic [7:0] TEMP_MASK   = 8'h83;
    localparam logic [7:0] REMOTE_MASK = 8'h81;

    // register offsets
    localparam logic [7:0] ADDR_READING_BASE = 8'h20;
    localparam logic [7:0] ADDR_START        = 8'h40;
    localparam logic [7:0] ADDR_STATUS       = 8'h41;
    localparam logic [7:0] ADDR_LIMIT_BASE   = 8'h44;
    localparam logic [7:0] ADDR_FUNC         = 8'h7c;
    localparam logic [7:0] ADDR_CONFIGURATION_REGISTER         = 8'h7f;

    // field positions
    localparam int START_BIT    = 0;
    localparam int MODE_BIT     = 1;
    localparam int AVG_MSB      = 7;
    localparam int AVG_LSB      = 5;
    localparam int SOFT_RST_BIT = 7;

    // reset values
    localparam logic [7:0] START_RESET      = 8'h00;
    localparam logic [7:0] FUNC_RESET       = 8'h40;
    localparam logic [7:0] CONFIGURATION_REGISTER_RESET       = 8'h00;
    localparam logic [7:0] LOW_LIMIT_RESET  = 8'h00;
    localparam logic [7:0] HIGH_LIMIT_RESET = 8'hff;

    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcs_reg_req_s;

endpackage

// *** hw/mcs_avg_decode.sv ***
// priority decoder of the averaging select field into a log2 sample count
`timescale 1ns/10ps
module mcs_avg_decode (
    input  wire logic [2:0] average_count_select_in,
    input  wire logic       is_remote_in,
    output logic      [2:0] log2_samples_out
);

    always_comb begin
        if (average_count_select_in[2]) begin
            log2_samples_out = 3'h5;
        end else if (average_count_select_in[1]) begin
            log2_samples_out = 3'h4;
        end else if (average_count_select_in[0]) begin
            log2_samples_out = is_remote_in ? 3'h4 : 3'h0;
        end else begin
            log2_samples_out = is_remote_in ? 3'h7 : 3'h3;
        end
    end

endmodule

// *** hw/mcs_tick_gen.sv ***
// divider making the conversion clock and its one-cycle tick
`timescale 1ns/10ps
module mcs_tick_gen #(
    parameter int DIV = 2222
) (
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    input  wire logic clear_in,
    output logic      tick_out,
    output logic      level_out
);

    localparam int CW = $clog2(DIV + 1);

    logic [CW-1:0] count;

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || clear_in) begin
            count <= '0;
        end else if (count == CW'(DIV - 1)) begin
            count <= '0;
        end else begin
            count <= count + CW'(1);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || clear_in) begin
            tick_out  <= 1'b0;
            level_out <= 1'b0;
        end else begin
            tick_out  <= (count == CW'(DIV - 1));
            level_out <= (count < CW'(DIV / 2));
        end
    end

endmodule

// *** dv/mcs_sequencer_checker.sv ***
// port assertions for the monitor conversion sequencer
`timescale 1ns/10ps
module mcs_sequencer_checker #(
    parameter int CONV_DIV_P   = mcs_pkg::CONV_DIV,
    parameter int IDLE_TICKS_P = mcs_pkg::IDLE_TICKS
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_n_in,
    input  wire mcs_pkg::mcs_reg_req_s reg_req_in,
    input  wire logic            [7:0] reg_rdata_out,
    input  wire logic            [7:0] adc_sample_in,
    input  wire logic                  adc_clk_out,
    input  wire logic                  adc_convert_out,
    input  wire logic            [2:0] adc_channel_out,
    input  wire logic                  monitoring_out
);
    import mcs_pkg::*;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire [7:0] wd       = reg_req_in.wdata;
    wire       wr_func  = reg_req_in.wr && !reg_req_in.rd && reg_req_in.addr == ADDR_FUNC;
    wire       rd_func  = reg_req_in.rd && !reg_req_in.wr && reg_req_in.addr == ADDR_FUNC;
    wire       wr_start = reg_req_in.wr && reg_req_in.addr == ADDR_START;
    wire       wr_soft  = reg_req_in.wr && reg_req_in.addr == ADDR_CONFIGURATION_REGISTER && wd[SOFT_RST_BIT];
    wire       rd_configuration_register  = reg_req_in.rd && reg_req_in.addr == ADDR_CONFIGURATION_REGISTER;

    property p_reset_quiet;
        $rose(rst_n_in) |-> !monitoring_out && !adc_convert_out && adc_channel_out == 3'h0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not clear after reset");
    property p_chan_order;
        $changed(adc_channel_out) |->
            adc_channel_out == $past(adc_channel_out) + 3'h1 || adc_channel_out == 3'h0;
    endproperty
    a_chan_order: assert property (p_chan_order)
        else $error("slot order broken");
    property p_chan_hold;
        $changed(adc_channel_out) && monitoring_out |=> $stable(adc_channel_out)[*8];
    endproperty
    a_chan_hold: assert property (p_chan_hold)
        else $error("slot left too early");
    property p_func_back;
        wr_func ##1 rd_func |=> reg_rdata_out == $past(wd, 2);
    endproperty
    a_func_back: assert property (p_func_back)
        else $error("function register readback wrong");
    property p_soft_idle;
        wr_soft |-> ##[1:4] (!monitoring_out && !adc_convert_out);
    endproperty
    a_soft_idle: assert property (p_soft_idle)
        else $error("soft reset left sequencer busy");
    property p_soft_configuration_register;
        wr_soft ##[2:6] rd_configuration_register |=> reg_rdata_out == CONFIGURATION_REGISTER_RESET;
    endproperty
    a_soft_configuration_register: assert property (p_soft_configuration_register)
        else $error("soft reset bit not self clearing");
    property p_start_run;
        wr_start && wd[START_BIT] && !monitoring_out |-> ##[1:4] monitoring_out;
    endproperty
    a_start_run: assert property (p_start_run)
        else $error("start did not begin monitoring");
    property p_stop_idle;
        wr_start && !wd[START_BIT] |-> ##[1:4] (!monitoring_out[*8]);
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("clear start did not idle");
endmodule

// *** dv/mcs_sequencer_tb.sv ***
// self-checking testbench for the monitor conversion sequencer
`timescale 1ns/10ps
module mcs_sequencer_tb;
    import mcs_pkg::*;
    localparam int DIV  = 2;
    localparam int IDLE = 8;
    localparam int TS   = 96 * DIV;
    localparam int VS   = 68 * DIV;
    logic         core_clk_in   = 1'b0;
    logic         rst_n_in      = 1'b0;
    mcs_reg_req_s reg_req_in    = '0;
    logic [7:0]   adc_sample_in = 8'h00;
    logic [7:0]   reg_rdata_out;
    logic         adc_clk_out;
    logic         adc_convert_out;
    logic [2:0]   adc_channel_out;
    logic         monitoring_out;
    logic [2:0]   prev_ch = 3'h0;
    int           error_cnt = 0;
    int           checked = 0;
    int           dur [8];
    int           run_len = 0;
    int           low_len = 0;
    int           low_max = 0;
    int           order [$];

    mcs_sequencer #(.CONV_DIV_P(DIV), .IDLE_TICKS_P(IDLE)) dut_u (
        .core_clk_in     (core_clk_in),
        .rst_n_in        (rst_n_in),
        .reg_req_in      (reg_req_in),
        .reg_rdata_out   (reg_rdata_out),
        .adc_sample_in   (adc_sample_in),
        .adc_clk_out     (adc_clk_out),
        .adc_convert_out (adc_convert_out),
        .adc_channel_out (adc_channel_out),
        .monitoring_out  (monitoring_out)
    );

    always #5 core_clk_in = ~core_clk_in;

    function automatic logic [7:0] val(input int i);
        return 8'(8'h40 + 4 * i);
    endfunction

    // per-slot sample source, slot timing and clock pause tracking
    always @(negedge core_clk_in) begin
        adc_sample_in <= val(int'(adc_channel_out));
        low_len = adc_clk_out ? 0 : low_len + 1;
        low_max = (low_len > low_max) ? low_len : low_max;
        if (adc_channel_out !== prev_ch) begin
            order.push_back(int'(adc_channel_out));
            dur[prev_ch] = run_len;
            run_len = 1;
        end else begin
            run_len = monitoring_out ? run_len + 1 : 0;
        end
        prev_ch = adc_channel_out;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %0h want %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        reg_req_in <= '{1'b1, 1'b0, a, d};
        @(negedge core_clk_in);
        reg_req_in <= '0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(negedge core_clk_in);
        reg_req_in <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk_in);
        reg_req_in <= '0;
        chk(reg_rdata_out, exp, msg);
    endtask

    task automatic wait_ch(input logic [2:0] ch, input int lim);
        int n;
        n = 0;
        while (adc_channel_out !== ch && n < lim) begin
            @(negedge core_clk_in);
            n++;
        end
        chk(n < lim, 1, "slot wait");
    endtask

    task automatic stop_run(input logic [7:0] f);
        reg_wr(ADDR_START, 8'h00);
        repeat (12) @(negedge core_clk_in);
        reg_wr(ADDR_FUNC, f);
        reg_wr(ADDR_START, 8'h01);
    endtask

    task automatic t_reset_vals;
        rchk(ADDR_FUNC, 8'h40, "func reset");
        rchk(ADDR_START, 8'h00, "start reset");
        rchk(ADDR_LIMIT_BASE, 8'h00, "low limit reset");
        rchk(8'h53, 8'hff, "high limit reset");
        rchk(ADDR_CONFIGURATION_REGISTER, 8'h00, "configuration_register reset");
        reg_wr(ADDR_STATUS, 8'hff);
        reg_wr(8'h10, 8'h5a);
        rchk(ADDR_STATUS, 8'h00, "status");
        rchk(8'h10, 8'h00, "unmapped");
        repeat (40) @(negedge core_clk_in);
        chk(monitoring_out, 1'b0, "idle run");
        chk(adc_convert_out, 1'b0, "idle convert");
    endtask

    task automatic t_cont;
        @(negedge core_clk_in);
        reg_req_in <= '{1'b1, 1'b0, ADDR_FUNC, 8'h20};
        @(negedge core_clk_in);
        reg_req_in <= '{1'b0, 1'b1, ADDR_FUNC, 8'h00};
        @(negedge core_clk_in);
        reg_req_in <= '0;
        chk(reg_rdata_out, 8'h20, "func back");
        reg_wr(8'h49, val(2));
        reg_wr(8'h4b, val(3) - 8'h01);
        reg_wr(8'h4c, val(4) + 8'h01);
        order.delete();
        reg_wr(ADDR_START, 8'h01);
        for (int p = 0; p < 2; p++) begin
            wait_ch(3'h7, 9000);
            wait_ch(3'h0, 4000);
            repeat (20) @(negedge core_clk_in);
            if (p == 0) low_max = 0;
        end
        chk(low_max <= 8, 1, "pause");
        chk(adc_convert_out, 1'b1, "converting");
        for (int i = 0; i < 16; i++) chk(order[i], (i + 1) % 8, "order");
        chk(dur[1] inside {[TS - 4 : TS + 4]}, 1, "ambient");
        for (int i = 2; i < 7; i++) chk(dur[i] inside {[VS - 4 : VS + 4]}, 1, "volt");
        chk(dur[7] inside {[16 * TS - 4 : 16 * TS + 4]}, 1, "remote");
        for (int i = 0; i < 8; i++) rchk(8'(ADDR_READING_BASE + i), val(i), "reading");
        rchk(ADDR_STATUS, 8'h18, "limits");
        rchk(ADDR_STATUS, 8'h18, "sticky");
        reg_wr(8'h4b, 8'hff);
        reg_wr(8'h4c, 8'h00);
        reg_wr(ADDR_FUNC, 8'h60);
        wait_ch(3'h7, 9000);
        chk(dur[1] inside {[TS - 4 : TS + 4]}, 1, "late avg");
        wait_ch(3'h0, 4000);
        rchk(ADDR_STATUS, 8'h18, "kept");
        rchk(ADDR_STATUS, 8'h00, "cleared");
    endtask

    task automatic t_cycle;
        stop_run(8'h22);
        wait_ch(3'h7, 9000);
        low_max = 0;
        wait_ch(3'h0, 9000);
        wait_ch(3'h1, 9000);
        chk(low_max >= IDLE * DIV - 2, 1, "idle gap");
        rchk(ADDR_STATUS, 8'h04, "equal");
    endtask

    task automatic t_avg;
        logic [7:0] f [4] = '{8'h00, 8'h20, 8'h60, 8'ha0};
        int         r [4] = '{128, 16, 16, 32};
        int         o [4] = '{8, 1, 16, 32};
        for (int k = 0; k < 4; k++) begin
            stop_run(f[k]);
            wait_ch(3'h1, 30000);
            wait_ch(3'h2, 30000);
            @(negedge core_clk_in);
            chk(dur[0] inside {[r[k] * TS - 4 : r[k] * TS + 4]}, 1, "remote n");
            chk(dur[1] inside {[o[k] * TS - 4 : o[k] * TS + 4]}, 1, "ambient n");
        end
    endtask

    task automatic t_soft;
        reg_wr(ADDR_LIMIT_BASE, 8'h12);
        reg_wr(ADDR_CONFIGURATION_REGISTER, 8'h80);
        repeat (3) @(negedge core_clk_in);
        chk(monitoring_out, 1'b0, "soft idle");
        rchk(ADDR_CONFIGURATION_REGISTER, 8'h00, "self clear");
        rchk(ADDR_FUNC, 8'h40, "func");
        rchk(ADDR_START, 8'h00, "start");
        rchk(ADDR_STATUS, 8'h00, "status cleared");
        rchk(ADDR_LIMIT_BASE, 8'h00, "limit");
        rchk(8'h21, val(1), "reading kept");
    endtask

    initial begin
        repeat (8) @(negedge core_clk_in);
        rst_n_in <= 1'b1;
        t_reset_vals();
        t_cont();
        t_cycle();
        t_avg();
        t_soft();
        tally_and_finish();
    end

    initial begin
        #950_000;
        error_cnt++;
        tally_and_finish();
    end
endmodule

bind mcs_sequencer mcs_sequencer_checker #(
    .CONV_DIV_P   (CONV_DIV_P),
    .IDLE_TICKS_P (IDLE_TICKS_P)
) chk_u (
    .core_clk_in     (core_clk_in),
    .rst_n_in        (rst_n_in),
    .reg_req_in      (reg_req_in),
    .reg_rdata_out   (reg_rdata_out),
    .adc_sample_in   (adc_sample_in),
    .adc_clk_out     (adc_clk_out),
    .adc_convert_out (adc_convert_out),
    .adc_channel_out (adc_channel_out),
    .monitoring_out  (monitoring_out)
);
